// ===== gpet_edge.sv
// GPIO edge-trigger enables, pending status and bank interrupt
//
// Strobed register access and the register addresses were chosen for this implementation.
module gpet_edge
   import gpet_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire gpet_bus_req_type bus_req,
   input  wire logic [103:0]     gpio_pin,
   output logic      [31:0]      rdata,
   output logic      [103:0]     pending_event,
   output logic                  irq
);
   logic [PIN_COUNT-1:0]  pin_meta;
   logic [PIN_COUNT-1:0]  pin_sync;
   logic [PIN_COUNT-1:0]  pin_prev;
   logic [PIN_COUNT-1:0]  rise_en;
   logic [PIN_COUNT-1:0]  fall_en;
   logic [BANK_COUNT-1:0] bank_irq_en;

   logic [PIN_COUNT-1:0]  next_rise_en;
   logic [PIN_COUNT-1:0]  next_fall_en;
   logic [PIN_COUNT-1:0]  next_pending;
   logic [BANK_COUNT-1:0] next_bank_irq_en;
   logic [31:0]           next_rdata;
   logic                  next_irq;
   logic [PIN_COUNT-1:0]  next_pin_meta;
   logic [PIN_COUNT-1:0]  next_pin_sync;
   logic [PIN_COUNT-1:0]  next_pin_prev;

   gpet_sel_type          sel;
   logic [1:0]            word;
   logic [6:0]            shamt;
   logic [31:0]           set_lane;
   logic [31:0]           clr_lane;
   logic [127:0]          set_mask;
   logic [127:0]          clr_mask;
   logic [127:0]          w1c_mask;
   logic [127:0]          rise_pad;
   logic [127:0]          fall_pad;
   logic [127:0]          pend_pad;
   logic [127:0]          rd_shift;
   logic [PIN_COUNT-1:0]  edge_evt;
   logic [PIN_COUNT-1:0]  rise_evt;
   logic [PIN_COUNT-1:0]  fall_evt;
   logic [PIN_COUNT-1:0]  bank_gate;

   // Register decode
   always_comb
   begin
      word  = bus_req.addr[3:2];
      shamt = {word, 5'h00};
      sel   = SEL_NONE;
      if (bus_req.addr[1:0] != 2'h0)
      begin
         sel = SEL_NONE;
      end
      else if (bus_req.addr == OFS_BANK_IRQ_EN)
      begin
         sel = SEL_BANK_IRQ;
      end
      else if (bus_req.addr[7:4] == GRP_RISE_SET)
      begin
         sel = SEL_RISE_SET;
      end
      else if (bus_req.addr[7:4] == GRP_RISE_CLR)
      begin
         sel = SEL_RISE_CLR;
      end
      else if (bus_req.addr[7:4] == GRP_FALL_SET)
      begin
         sel = SEL_FALL_SET;
      end
      else if (bus_req.addr[7:4] == GRP_FALL_CLR)
      begin
         sel = SEL_FALL_CLR;
      end
      else if (bus_req.addr[7:4] == GRP_PENDING)
      begin
         sel = SEL_PENDING;
      end
   end

   // Enable group: one strobe per write, so a set and a clear land in order
   always_comb
   begin
      // Bank 6 word only has eight pins; pin 103 cannot be cleared
      set_lane = (word == LAST_WORD) ? LAST_SET_MASK : FULL_WORD_MASK;
      clr_lane = (word == LAST_WORD) ? LAST_CLR_MASK : FULL_WORD_MASK;
      // Word n bit b is pin 32n+b: bits 15-0 even bank, 31-16 odd bank
      set_mask = {96'h0, bus_req.wdata & set_lane} << shamt;
      clr_mask = {96'h0, bus_req.wdata & clr_lane} << shamt;
      rise_pad = {{PAD_WIDTH{1'b0}}, rise_en};
      fall_pad = {{PAD_WIDTH{1'b0}}, fall_en};

      if (bus_req.wr)
      begin
         if (sel == SEL_RISE_SET)
         begin
            rise_pad = rise_pad | set_mask;
         end
         else if (sel == SEL_RISE_CLR)
         begin
            rise_pad = rise_pad & ~clr_mask;
         end
         else if (sel == SEL_FALL_SET)
         begin
            fall_pad = fall_pad | set_mask;
         end
         else if (sel == SEL_FALL_CLR)
         begin
            fall_pad = fall_pad & ~clr_mask;
         end
      end
      next_rise_en = rise_pad[PIN_COUNT-1:0];
      next_fall_en = fall_pad[PIN_COUNT-1:0];
   end

   // Enables change only on a write or a reset
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rise_en <= ENABLE_RESET;
         fall_en <= ENABLE_RESET;
      end
      else
      begin
         rise_en <= next_rise_en;
         fall_en <= next_fall_en;
      end
   end

   // Synchroniser group: the pins belong to no clock, so two stages come first
   always_comb
   begin
      next_pin_meta = gpio_pin;
      next_pin_sync = pin_meta;
      next_pin_prev = pin_sync;
   end

   // A pin high at release looks like a rise, but enables are still zero
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pin_meta <= ENABLE_RESET;
         pin_sync <= ENABLE_RESET;
         pin_prev <= ENABLE_RESET;
      end
      else
      begin
         pin_meta <= next_pin_meta;
         pin_sync <= next_pin_sync;
         pin_prev <= next_pin_prev;
      end
   end

   // Pending group: sticky bits, and an edge beats a clear in the same cycle
   always_comb
   begin
      rise_evt = pin_sync & ~pin_prev;
      fall_evt = ~pin_sync & pin_prev;
      // Either transition may fire when both enables are on
      edge_evt = (rise_evt & rise_en) | (fall_evt & fall_en);

      w1c_mask = {96'h0, bus_req.wdata & set_lane} << shamt;
      pend_pad = {{PAD_WIDTH{1'b0}}, pending_event};

      if (bus_req.wr && sel == SEL_PENDING)
      begin
         pend_pad = pend_pad & ~w1c_mask;
      end
      // Event set wins over a same-cycle software clear
      next_pending = pend_pad[PIN_COUNT-1:0] | edge_evt;
   end

   // Status only falls on a write of one or a reset
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pending_event <= PENDING_RESET;
      end
      else
      begin
         pending_event <= next_pending;
      end
   end

   // Bank interrupt enable: a mask of seven bits, one per bank
   always_comb
   begin
      // Upper write data is dropped
      next_bank_irq_en = bank_irq_en;
      if (bus_req.wr && sel == SEL_BANK_IRQ)
      begin
         next_bank_irq_en = bus_req.wdata[BANK_COUNT-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         bank_irq_en <= BANK_IRQ_RESET;
      end
      else
      begin
         bank_irq_en <= next_bank_irq_en;
      end
   end

   // Interrupt group: registered, so it trails pending by one cycle
   always_comb
   begin
      bank_gate = '0;
      for (int b = 0; b < BANK_COUNT; b++)
      begin
         for (int i = 0; i < BANK_WIDTH; i++)
         begin
            // Bank 6 stops at pin 103
            if (b * BANK_WIDTH + i < PIN_COUNT)
            begin
               bank_gate[b * BANK_WIDTH + i] = bank_irq_en[b];
            end
         end
      end

      next_irq = |(pending_event & bank_gate);
   end

   // Registered so the interrupt pin comes straight from a flop
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= next_irq;
      end
   end

   // Read group: data stand one cycle after the strobe, zero otherwise
   always_comb
   begin
      // Both set and clear views return the live enable
      rd_shift = 128'h0;
      if (sel == SEL_RISE_SET)
      begin
         rd_shift = {{PAD_WIDTH{1'b0}}, rise_en} >> shamt;
      end
      else if (sel == SEL_RISE_CLR)
      begin
         rd_shift = {{PAD_WIDTH{1'b0}}, rise_en} >> shamt;
      end
      else if (sel == SEL_FALL_SET)
      begin
         rd_shift = {{PAD_WIDTH{1'b0}}, fall_en} >> shamt;
      end
      else if (sel == SEL_FALL_CLR)
      begin
         rd_shift = {{PAD_WIDTH{1'b0}}, fall_en} >> shamt;
      end
      else if (sel == SEL_PENDING)
      begin
         rd_shift = {{PAD_WIDTH{1'b0}}, pending_event} >> shamt;
      end
      else if (sel == SEL_BANK_IRQ)
      begin
         rd_shift = {121'h0, bank_irq_en};
      end

      next_rdata = UNMAPPED_READ;
      if (bus_req.rd)
      begin
         next_rdata = rd_shift[31:0];
         // Pin 103 clear bit is read-only and reads zero
         if (sel == SEL_RISE_CLR || sel == SEL_FALL_CLR)
         begin
            if (word == LAST_WORD)
            begin
               next_rdata = rd_shift[31:0] & LAST_CLR_MASK;
            end
         end
      end
   end

   // Read data flop doubles as the output register
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rdata <= UNMAPPED_READ;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end
endmodule

// ===== gpet_edge_asserts.sv
// Port assertions for the edge-trigger enable block
module gpet_edge_asserts
   import gpet_pkg::*;
(
   input wire logic             clk,
   input wire logic             resetn,
   input wire gpet_bus_req_type bus_req,
   input wire logic [103:0]     gpio_pin,
   input wire logic [31:0]      rdata,
   input wire logic [103:0]     pending_event,
   input wire logic             irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_RESET_ZERO: assert property (disable iff (1'b0) !resetn |=> !irq && pending_event == 0)
      else $error("state kept over reset");
   AST_LAST_UPPER: assert property (bus_req.rd && bus_req.addr[3:0] == 4'hc
      |=> rdata[31:8] == 24'h0) else $error("reserved bits set");
   AST_CLR_BIT7: assert property (bus_req.rd && (bus_req.addr == 8'h2c || bus_req.addr == 8'h4c)
      |=> rdata[31:7] == 25'h0) else $error("clear word bit 7 set");
   AST_RISE_SET: assert property (bus_req.wr && bus_req.addr == 8'h10 ##1 bus_req.rd &&
      bus_req.addr == 8'h20 |=> (rdata & $past(bus_req.wdata, 2)) == $past(bus_req.wdata, 2))
      else $error("rise set lost");
   AST_FALL_SET: assert property (bus_req.wr && bus_req.addr == 8'h30 ##1 bus_req.rd &&
      bus_req.addr == 8'h40 |=> (rdata & $past(bus_req.wdata, 2)) == $past(bus_req.wdata, 2))
      else $error("fall set lost");
   AST_PEND_KEEP: assert property (($past(pending_event) & ~pending_event) != 0 |->
      $past(bus_req.wr) && $past(bus_req.addr[7:4]) == GRP_PENDING) else $error("pending lost");
   AST_PEND_EDGE: assert property ((pending_event & ~$past(pending_event)
      & ~($past(gpio_pin, 3) ^ $past(gpio_pin, 4)) & ~($past(gpio_pin, 4) ^ $past(gpio_pin, 5)))
      == 104'h0) else $error("pending without edge");
   AST_IRQ_CAUSE: assert property (irq |-> $past(pending_event) != 0)
      else $error("irq without pending");
endmodule
bind gpet_edge gpet_edge_asserts u_chk (.clk(clk), .resetn(resetn), .bus_req(bus_req),
   .gpio_pin(gpio_pin), .rdata(rdata), .pending_event(pending_event), .irq(irq));

// ===== gpet_pins.sv
// External pin drivers for the edge-trigger block
module gpet_pins
(
   input  wire logic         clk,
   input  wire logic [103:0] level,
   output logic      [103:0] gpio_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Levels move only at an edge, so every pulse lasts at least one cycle
   initial gpio_pin = '0;
   always @(posedge clk) gpio_pin <= level;
endmodule

// ===== gpet_pkg.sv
// Constants, types and register map of the GPIO edge-trigger enable block
// Operation
// - Writing one to a rise-set bit enables that pin's rising edge; zero does nothing.
// - Writing one to a rise-clear bit disables that pin's rising edge; zero does nothing.
// - Rise-set and rise-clear reads both return the current rising enable.
// - Bits 31-16 of each paired register serve the odd bank of the pair.
// - Bits 15-0 of each register serve the even bank, banks 0, 2, 4 and 6.
// - Banks 4-5 registers map bit 0 to pin 64 up to bit 31 to pin 95.
// - Bank 6 rise-set holds bits 7-0 for pins 96-103; upper bits read zero.
// - Bank 6 rise-clear bit 7 reads zero, cannot write; bits 6-0 writable.
// - Reset clears all rising and falling enables.
// - Writing one to a fall-set bit enables falling edge; same layout as rising.
// - Fall-set and fall-clear reads both return the current falling enable.
// - Writing one to a fall-clear bit disables falling edge; zero does nothing.
// - An enabled edge sets pending; software clears by writing one, zero ignored.
package gpet_pkg;
   localparam int PIN_COUNT  = 104;
   localparam int WORD_COUNT = 4;
   localparam int BANK_COUNT = 7;
   localparam int BANK_WIDTH = 16;
   localparam int PAD_WIDTH  = WORD_COUNT * 32 - PIN_COUNT;

   // Word offsets inside each group are base plus four times the word index
   localparam logic [7:0] OFS_BANK_IRQ_EN = 8'h00;
   localparam logic [3:0] GRP_RISE_SET    = 4'h1;
   localparam logic [3:0] GRP_RISE_CLR    = 4'h2;
   localparam logic [3:0] GRP_FALL_SET    = 4'h3;
   localparam logic [3:0] GRP_FALL_CLR    = 4'h4;
   localparam logic [3:0] GRP_PENDING     = 4'h5;

   localparam logic [1:0]  LAST_WORD       = 2'h3;
   localparam logic [31:0] FULL_WORD_MASK  = 32'hffffffff;
   localparam logic [31:0] LAST_SET_MASK   = 32'h000000ff;
   localparam logic [31:0] LAST_CLR_MASK   = 32'h0000007f;
   localparam logic [31:0] UNMAPPED_READ   = 32'h00000000;

   localparam logic [PIN_COUNT-1:0]  ENABLE_RESET   = 104'h0;
   localparam logic [PIN_COUNT-1:0]  PENDING_RESET  = 104'h0;
   localparam logic [BANK_COUNT-1:0] BANK_IRQ_RESET = 7'h00;

   typedef enum logic [2:0] {
      SEL_NONE     = 3'b000,
      SEL_BANK_IRQ = 3'b001,
      SEL_RISE_SET = 3'b010,
      SEL_RISE_CLR = 3'b011,
      SEL_FALL_SET = 3'b100,
      SEL_FALL_CLR = 3'b101,
      SEL_PENDING  = 3'b110
   } gpet_sel_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } gpet_bus_req_type;
endpackage

// ===== tb.sv
// Self-checking bench for the edge-trigger enable block
`define CHK(v, e) begin cmp_count++; if ((v) !== (e)) begin fails++; \
   $display("wrong value at %0t got %h expected %h", $time, v, e); end end
module tb
   import gpet_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk = 1'b0;
   logic             resetn = 1'b0;
   gpet_bus_req_type req = '0;
   logic [103:0]     lvl = '0;
   logic [103:0]     gpio_pin, pending_event;
   logic [31:0]      rdata;
   logic             irq;
   logic [127:0]     rise = '0, fall = '0;
   logic [15:0]      seed = 16'hb7ec;
   logic [3:0]       g, p;
   logic [1:0]       w;
   int               fails = 0;
   int               cmp_count = 0;
   always #50 clk = ~clk;
   gpet_pins u_pins (.clk(clk), .level(lvl), .gpio_pin(gpio_pin));
   gpet_edge dut (.clk(clk), .resetn(resetn), .bus_req(req), .gpio_pin(gpio_pin),
      .rdata(rdata), .pending_event(pending_event), .irq(irq));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Last word: pin 103 can be set but never cleared
   function automatic logic [31:0] msk(input logic [1:0] x, input logic clr);
      return (x != LAST_WORD) ? FULL_WORD_MASK : (clr ? LAST_CLR_MASK : LAST_SET_MASK);
   endfunction
   function automatic logic [31:0] expv(input logic [3:0] q, input logic [1:0] x);
      return (q < 4'h3 ? rise[32*x+:32] : fall[32*x+:32]) & msk(x, ~q[0]);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk) req.rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk) req <= '0;
      #1;
   endtask
   task automatic mwr(input logic [3:0] q, input logic [1:0] x, input logic [31:0] v);
      logic [127:0] m;
      m = 128'(v & msk(x, ~q[0])) << (32 * x);
      wr({q, x, 2'b00}, v);
      case (q)
         GRP_RISE_SET: rise |= m;
         GRP_RISE_CLR: rise &= ~m;
         GRP_FALL_SET: fall |= m;
         default:      fall &= ~m;
      endcase
   endtask
   task automatic chk_all();
      for (int k = 4; k < 20; k++)
         rd(8'(k * 4), expv(4'(k / 4), 2'(k)));
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      chk_all();
      $display("test reset done");
      mwr(GRP_RISE_SET, 2'h0, 32'h20);
      mwr(GRP_FALL_SET, 2'h2, 32'h40);
      wr(OFS_BANK_IRQ_EN, 32'h7f);
      @(posedge clk)
      begin
         req <= '0;
         lvl <= (104'h1 << 70) | 104'h20;
      end
      idle(6);
      `CHK(pending_event, 104'h20)
      @(posedge clk) lvl <= '0;
      idle(6);
      `CHK(pending_event, (104'h1 << 70) | 104'h20)
      rd(8'h58, 32'h40);
      wr(OFS_BANK_IRQ_EN, 32'h0);
      idle(2);
      `CHK(irq, 1'b0)
      wr(OFS_BANK_IRQ_EN, 32'h7f);
      rd(OFS_BANK_IRQ_EN, 32'h7f);
      wr(8'h50, 32'h0);
      wr(8'h58, 32'h40);
      idle(2);
      `CHK(pending_event, 104'h20)
      `CHK(irq, 1'b1)
      wr(8'h50, 32'h20);
      idle(2);
      `CHK(irq | (|pending_event), 1'b0)
      // Rise on pin 5 meets a clear of pin 5 in the same cycle: set wins
      @(posedge clk) lvl <= 104'h20;
      idle(2);
      wr(8'h50, 32'h20);
      idle(2);
      `CHK(pending_event, 104'h20)
      wr(8'h50, 32'h20);
      $display("test edges done");
      // Set then clear one pin with no gap, then pin 103 which cannot clear
      mwr(GRP_RISE_SET, 2'h0, 32'h8);
      mwr(GRP_RISE_CLR, 2'h0, 32'h8);
      mwr(GRP_FALL_SET, 2'h3, 32'h80);
      mwr(GRP_FALL_CLR, 2'h3, 32'hffffffff);
      for (int i = 0; i < 48; i++)
      begin
         seed = lfsr(seed);
         g = 4'(1 + i % 4);
         w = (i < 4) ? 2'h0 : seed[1:0];
         p = g[0] ? g + 4'h1 : g - 4'h1;
         mwr(g, w, {seed, lfsr(seed)});
         seed = lfsr(lfsr(seed));
         rd({p, w, 2'b00}, expv(p, w));
      end
      wr(8'h61, 32'hffffffff);
      rd(8'h60, 32'h0);
      chk_all();
      $display("test random done");
      @(posedge clk) resetn <= 1'b0;
      idle(2);
      @(posedge clk) resetn <= 1'b1;
      rise = '0;
      fall = '0;
      chk_all();
      $display("test second reset done");
      summarize();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule
